// ==== pkg/cessq_pkg.sv ====
`default_nettype none
package cessq_pkg;

	// System clock rate.
	localparam int unsigned CLK_HZ = 25000000;
	// Temperature PWM rate and its period in cycles.
	localparam int unsigned PWM_HZ = 250000;
	localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
	// Start-up delays in their printed units.
	localparam int unsigned START_DELAY_MS = 10;
	localparam int unsigned READY_DELAY_MS = 2;
	localparam int unsigned TEMP_VALID_US = 100;
	localparam int unsigned FAULT_RESP_US = 10;
	// Start-up delays in clock cycles.
	localparam int unsigned START_DELAY_CYC = CLK_HZ / 1000 * START_DELAY_MS;
	localparam int unsigned READY_DELAY_CYC = CLK_HZ / 1000 * READY_DELAY_MS;
	localparam int unsigned TEMP_VALID_CYC = CLK_HZ / 1000000 * TEMP_VALID_US;
	localparam int unsigned FAULT_RESP_CYC = CLK_HZ / 1000000 * FAULT_RESP_US;
	// Temperature code to duty: duty = (100 + T) / 330, clamped in percent-hundredths.
	localparam int unsigned TEMP_OFFSET_C = 100;
	localparam int unsigned TEMP_SPAN_C = 330;
	localparam int unsigned DUTY_MIN_CHUNDREDTHS = 1818;
	localparam int unsigned DUTY_MAX_CHUNDREDTHS = 6818;
	// Clamp limits expressed in cycles of the PWM period.
	localparam int unsigned DUTY_MIN_CYC = (PWM_PERIOD_CYC * DUTY_MIN_CHUNDREDTHS + 9999) / 10000;
	localparam int unsigned DUTY_MAX_CYC = (PWM_PERIOD_CYC * DUTY_MAX_CHUNDREDTHS) / 10000;

	// Sequencer states.
	typedef enum logic [2:0] {
		CESSQ_OFF,
		CESSQ_QUAL,
		CESSQ_START,
		CESSQ_SOFT,
		CESSQ_READY,
		CESSQ_FAULT
	} cessq_state_type;

endpackage
`default_nettype wire

// ==== logic/cessq_pwm.sv ====
`timescale 1ns/1ns
`default_nettype none
// Temperature PWM generator: idles high, encodes the duty while enabled.
module cessq_pwm
	import cessq_pkg::*;
#(
	parameter int unsigned PERIOD_CYC = PWM_PERIOD_CYC
)(
	// Clock and reset.
	input  wire logic        sys_clk_in,
	input  wire logic        srst_in,
	// Control.
	input  wire logic        run_in,
	input  wire logic signed [8:0] temp_c_in,
	// Pin level.
	output logic             pwm_out
);

	// Converts a temperature to a clamped high time in cycles.
	function automatic logic [7:0] duty_cyc(input logic signed [8:0] t);
		int signed d;
		d = ((int'(t) + int'(TEMP_OFFSET_C)) * int'(PERIOD_CYC)) / int'(TEMP_SPAN_C);
		if (d < int'(DUTY_MIN_CYC)) begin
			d = int'(DUTY_MIN_CYC);
		end
		if (d > int'(DUTY_MAX_CYC)) begin
			d = int'(DUTY_MAX_CYC);
		end
		return d[7:0];
	endfunction

	logic [7:0] cnt_ff;   // Position within the period.
	logic [7:0] high_ff;  // High time latched at period start.

	// Period counter with the duty latched once per period.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || !run_in) begin
			cnt_ff  <= 8'h00;
			high_ff <= 8'h00;
		end else if (cnt_ff == 8'(PERIOD_CYC - 1)) begin
			cnt_ff  <= 8'h00;
			high_ff <= duty_cyc(temp_c_in);
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	// Pin stays high while idle, like the pull-up, else follows the duty.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || !run_in) begin
			pwm_out <= 1'b1;
		end else begin
			pwm_out <= (high_ff != 8'h00) ? (cnt_ff < high_ff) : 1'b1;
		end
	end

	// The duty latched while running stays inside the clamp window.
	a_duty_clamp: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(run_in && high_ff != 8'h00) |-> (high_ff >= 8'(DUTY_MIN_CYC) && high_ff <= 8'(DUTY_MAX_CYC)))
		else $error("duty outside clamp");

endmodule
`default_nettype wire

// ==== logic/cessq_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module cessq_top
	import cessq_pkg::*;
#(
	parameter int unsigned START_CYC = START_DELAY_CYC,
	parameter int unsigned READY_CYC = READY_DELAY_CYC,
	parameter int unsigned QUAL_CYC  = 16,
	parameter int unsigned TM_CYC    = TEMP_VALID_CYC
)(
	// Clock and reset.
	input  wire logic              sys_clk_in,
	input  wire logic              srst_in,
	// Enable pin: driven level and its drive flag.
	input  wire logic              enable_in,
	input  wire logic              enable_driven_in,
	// Supply and protection status.
	input  wire logic              pri_uv_ok_in,
	input  wire logic              ocp_in,
	input  wire logic              scp_in,
	input  wire logic              other_fault_in,
	// Internal temperature in Celsius.
	input  wire logic signed [8:0] temp_c_in,
	// Power stage control.
	output logic                   bias_en_out,
	output logic                   powertrain_en_out,
	// Status pins.
	output logic                   aux_ready_fault_flag,
	output logic                   temp_pwm_out
);

	cessq_state_type state_ff;     // Sequencer state.
	cessq_state_type nxt_state;    // Next sequencer state.
	logic [31:0]     tmr_ff;       // Delay timer within a state.
	logic [31:0]     tm_tmr_ff;    // Time since powertrain became active.
	logic            tm_run_ff;    // Temperature PWM running.
	logic            en_eff;       // Effective enable after pull-up.
	logic            fault;        // Any protection fault.
	logic            tmr_done;     // Current state's delay elapsed.

	// An undriven enable pin reads high through the pull-up.
	assign en_eff = enable_driven_in ? enable_in : 1'b1;
	// Overcurrent and short circuit count among the faults.
	assign fault = ocp_in | scp_in | other_fault_in;

	// Picks the delay that ends the current state.
	always_comb begin
		tmr_done = 1'b0;
		unique case (state_ff)
			CESSQ_QUAL:  tmr_done = (tmr_ff >= QUAL_CYC - 1);
			CESSQ_START: tmr_done = (tmr_ff >= START_CYC - 1);
			CESSQ_SOFT:  tmr_done = (tmr_ff >= READY_CYC - 1);
			CESSQ_OFF, CESSQ_READY, CESSQ_FAULT: tmr_done = 1'b0;
		endcase
	end

	// Next-state logic for the start-up sequence.
	always_comb begin
		nxt_state = state_ff;
		if (!en_eff) begin
			nxt_state = CESSQ_OFF;
		end else begin
			unique case (state_ff)
				// Wait for supply recovery.
				CESSQ_OFF: begin
					if (pri_uv_ok_in) begin
						nxt_state = CESSQ_QUAL;
					end
				end
				// Both conditions must hold through the qualification delay.
				CESSQ_QUAL: begin
					if (!pri_uv_ok_in) begin
						nxt_state = CESSQ_OFF;
					end else if (tmr_done) begin
						nxt_state = CESSQ_START;
					end
				end
				// Start delay before the powertrain activates.
				CESSQ_START: begin
					if (!pri_uv_ok_in) begin
						nxt_state = CESSQ_OFF;
					end else if (tmr_done) begin
						nxt_state = CESSQ_SOFT;
					end
				end
				// Soft-start with powertrain on.
				CESSQ_SOFT: begin
					if (fault) begin
						nxt_state = CESSQ_FAULT;
					end else if (!pri_uv_ok_in) begin
						nxt_state = CESSQ_OFF;
					end else if (tmr_done) begin
						nxt_state = CESSQ_READY;
					end
				end
				// Full power.
				CESSQ_READY: begin
					if (fault) begin
						nxt_state = CESSQ_FAULT;
					end else if (!pri_uv_ok_in) begin
						nxt_state = CESSQ_OFF;
					end
				end
				// Latched fault, left only by toggling enable off.
				CESSQ_FAULT: begin
					nxt_state = CESSQ_FAULT;
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_ff <= CESSQ_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Delay timer restarts on each state change.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || nxt_state != state_ff) begin
			tmr_ff <= 32'h0000_0000;
		end else if (!tmr_done) begin
			tmr_ff <= tmr_ff + 32'h0000_0001;
		end
	end

	// Bias follows enable; powertrain runs in soft-start and ready.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			bias_en_out       <= 1'b0;
			powertrain_en_out <= 1'b0;
		end else begin
			bias_en_out       <= en_eff;
			powertrain_en_out <= (nxt_state == CESSQ_SOFT) || (nxt_state == CESSQ_READY);
		end
	end

	// Ready flag high only after a completed soft-start and no fault.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			aux_ready_fault_flag <= 1'b0;
		end else begin
			aux_ready_fault_flag <= (nxt_state == CESSQ_READY) && !fault;
		end
	end

	// Temperature PWM starts a fixed time after powertrain activation.
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || !powertrain_en_out) begin
			tm_tmr_ff <= 32'h0000_0000;
			tm_run_ff <= 1'b0;
		end else if (tm_tmr_ff >= TM_CYC - 1) begin
			tm_run_ff <= 1'b1;
		end else begin
			tm_tmr_ff <= tm_tmr_ff + 32'h0000_0001;
		end
	end

	// Temperature PWM generator.
	cessq_pwm u_pwm (
		.sys_clk_in (sys_clk_in),
		.srst_in    (srst_in),
		.run_in     (tm_run_ff),
		.temp_c_in  (temp_c_in),
		.pwm_out    (temp_pwm_out)
	);

	// A fault drops the flag on the very next edge.
	a_fault_flag_drop: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		fault |=> !aux_ready_fault_flag)
		else $error("flag not low after fault");

	// Enable low shuts off bias and powertrain next edge.
	a_enable_low_off: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(enable_driven_in && !enable_in) |=> (!bias_en_out && !powertrain_en_out))
		else $error("bias or powertrain on while disabled");

	// Undriven enable acts as asserted.
	a_enable_pullup: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		!enable_driven_in |=> bias_en_out)
		else $error("undriven enable not treated as high");

	// Flag rises only with the powertrain already on.
	a_flag_needs_power: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		$rose(aux_ready_fault_flag) |-> ($past(powertrain_en_out) && powertrain_en_out))
		else $error("flag rose without powertrain");

	// Powertrain turns on only out of the start delay.
	a_power_from_start: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		$rose(powertrain_en_out) |-> $past(state_ff) == CESSQ_START)
		else $error("powertrain started without delay");

	// Overcurrent or short stops the powertrain.
	a_ocp_stop: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(ocp_in || scp_in) |=> !powertrain_en_out)
		else $error("powertrain ran through protection");

	// Temperature PWM idles high while powertrain is off.
	a_tm_idle_high: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(!powertrain_en_out ##1 !powertrain_en_out) |=> temp_pwm_out)
		else $error("temperature pin low while idle");

endmodule
`default_nettype wire

// ==== dv/cessq_ctrl_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// System controller model: drives the enable pin or leaves it to the pull-up.
module cessq_ctrl_model (
	// Clock.
	input  wire logic sys_clk_in,
	// Requests from the bench.
	input  wire logic drive_in,
	input  wire logic level_in,
	input  wire logic rev_load_in,
	// Enable pin as the device sees it.
	output var logic  enable_out = 1'b0,
	output var logic  enable_driven_out = 1'b1
);
	// A released pin shows a changing level so only the drive flag matters.
	always_ff @(posedge sys_clk_in) begin
		enable_driven_out <= drive_in;
		if (!drive_in) begin
			enable_out <= ~enable_out;
		end else if (!rev_load_in) begin
			enable_out <= level_in;
		end
	end
endmodule
`default_nettype wire

// ==== dv/cessq_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the enable and status sequencer.
module cessq_top_tb;
	import cessq_pkg::*;
	localparam int SC = 50; // Shortened start-up delay.
	localparam int RC = 20; // Shortened soft-start delay.
	localparam int QC = 16; // Qualification delay.
	localparam int TC = 10; // Shortened temperature delay.
	logic              sys_clk = 1'b0; // Bench clock.
	logic              srst = 1'b1; // Synchronous reset.
	logic              drive = 1'b1; // Controller drives enable.
	logic              level = 1'b0; // Driven enable level.
	logic              rev_load = 1'b0; // Loaded reverse run.
	logic              uv_ok = 1'b1; // Primary above recovery.
	logic        [2:0] flt = 3'h0; // Overcurrent, short, other.
	logic signed [8:0] temp = 9'h01B; // Internal temperature.
	logic              en_lvl, en_drv, bias, pt, flag, pwm; // Pin levels.
	logic        [7:0] lfsr = 8'h39; // Random state, seed 57.
	int                failures = 0; // Mismatches.
	int                check_count = 0; // Comparisons.
	int                cnt, hi, lo; // Cycle counters.
	int                tvals[5] = '{-100, -40, 27, 125, 155}; // Corner temperatures.

	// Clock at 25 MHz.
	initial forever #20 sys_clk = ~sys_clk;

	cessq_ctrl_model ctrl (.sys_clk_in(sys_clk), .drive_in(drive), .level_in(level),
		.rev_load_in(rev_load), .enable_out(en_lvl), .enable_driven_out(en_drv));

	cessq_top #(.START_CYC(SC), .READY_CYC(RC), .QUAL_CYC(QC), .TM_CYC(TC)) dut (
		.sys_clk_in(sys_clk), .srst_in(srst), .enable_in(en_lvl), .enable_driven_in(en_drv),
		.pri_uv_ok_in(uv_ok), .ocp_in(flt[0]), .scp_in(flt[1]), .other_fault_in(flt[2]),
		.temp_c_in(temp), .bias_en_out(bias), .powertrain_en_out(pt),
		.aux_ready_fault_flag(flag), .temp_pwm_out(pwm));

	// Compares a seen value with the expected one.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t saw %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Next random state.
	function automatic logic [7:0] next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Expected high time in cycles of a 100-cycle period.
	function automatic int duty_exp(input int t);
		int v;
		v = ((100 + t) * 100) / 330;
		return v < 19 ? 19 : (v > 68 ? 68 : v);
	endfunction

	// Moves to just after the next rising edge.
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask

	// Enables and follows the start-up to the first temperature pulse.
	task automatic startup(input logic drv);
		@(posedge sys_clk);
		drive <= drv;
		level <= 1'b1;
		cnt = 0;
		while (pt !== 1'b1 && cnt < 400) begin
			tick();
			cnt++;
		end
		check(cnt >= QC + SC && cnt <= QC + SC + 4, 1'b1);
		check(bias, 1'b1);
		cnt = 0;
		while (flag !== 1'b1 && cnt < 400) begin
			tick();
			cnt++;
		end
		check(cnt, RC);
		while (pwm !== 1'b0 && cnt < 400) begin
			tick();
			cnt++;
		end
		check(cnt >= TC + 1 && cnt <= TC + 202, 1'b1);
	endtask

	// Drives enable low and expects bias, powertrain and flag off.
	task automatic shutdown();
		@(posedge sys_clk);
		drive <= 1'b1;
		level <= 1'b0;
		repeat (3) tick();
		check({bias, pt, flag}, 3'h0);
	endtask

	// Measures one full PWM period from a rising edge.
	task automatic measure();
		cnt = 0;
		while (pwm !== 1'b0 && cnt < 300) begin
			tick();
			cnt++;
		end
		while (pwm !== 1'b1 && cnt < 600) begin
			tick();
			cnt++;
		end
		hi = 0;
		lo = 0;
		while (pwm === 1'b1 && hi < 300) begin
			tick();
			hi++;
		end
		while (pwm === 1'b0 && lo < 300) begin
			tick();
			lo++;
		end
	endtask

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		stop_test();
	end

	// Main sequence.
	initial begin
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		tick();
		check({bias, pt, flag, pwm}, 4'h1);
		startup(1'b0);
		for (int i = 0; i < 9; i++) begin
			int t;
			lfsr = next(lfsr);
			t = i < 5 ? tvals[i] : int'(lfsr) - 100;
			@(posedge sys_clk);
			temp <= t[8:0];
			repeat (3) measure();
			check(hi, duty_exp(t));
			check(hi + lo, PWM_PERIOD_CYC);
		end
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk);
			flt <= 3'h1 << k;
			tick();
			check({flag, pt}, 2'h0);
			@(posedge sys_clk);
			flt <= 3'h0;
			repeat (5) tick();
			check(flag, 1'b0);
			shutdown();
			startup(1'b1);
		end
		// Loss of the primary supply stops the powertrain without a latch.
		@(posedge sys_clk);
		uv_ok <= 1'b0;
		repeat (2) tick();
		check({flag, pt}, 2'h0);
		@(posedge sys_clk);
		uv_ok <= 1'b1;
		shutdown();
		stop_test();
	end
endmodule
`default_nettype wire
